// ==== pmic_ctl_consts.svh ====
// Register offsets, field positions, reset values and timings in nanoseconds of the control-pin block
`ifndef PMIC_CTL_CONSTS_SVH
`define PMIC_CTL_CONSTS_SVH

`define CLK_FREQ_HZ 40000000
// Register word byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_LATCH 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_MON_SELECT 8'h10
`define REG_OTP 8'h14
// Control register fields
`define CTRL_STBY_INV 0
`define CTRL_IRQ_TEST 1
`define CTRL_WD_STBY_EN 2
`define CTRL_RUN_LEVEL 3
`define CTRL_STBY_LEVEL 4
`define CTRL_OVLO_SDWN 5
// Interrupt latch fields
`define IRQ_EXT 0
`define IRQ_EARLY_WARNING_OUT 1
`define IRQ_OV 2
`define IRQ_UV 3
`define IRQ_WD 4
`define IRQ_COUNT 5
// Strap/fuse register fields
`define OTP_WD_EDGE 0
`define OTP_WD_TYPE 1
`define OTP_WD_STBY 2
`define OTP_PG_MODE 3
`define OTP_EW_TIME 4
// Reset values
`define MASK_RESET 5'h1F
`define MON_SELECT_RESET 11'h7FF
// Timing, in nanoseconds
`define IRQ_TEST_NS 100000
`define WD_DEBOUNCE_NS 10000
`define EW_T0_NS 100000
`define EW_T1_NS 5000000
`define EW_T2_NS 20000000
`define EW_T3_NS 50000000
`define NS_TO_CYC(ns) ((ns) / (1000000000 / `CLK_FREQ_HZ))

`endif

// ==== pmic_ctl_pkg.sv ====
// Types shared by the control-pin block
package pmic_ctl_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_POWER_UP,
        ST_RUN,
        ST_STANDBY,
        ST_WARN,
        ST_POWER_DOWN
    } sys_state_t;
endpackage

// ==== pmic_control_pin_logic.sv ====
// Control-pin logic of the power manager: standby, resets, interrupts, watchdog, early warning, power good
//
// Functional notes
// - Standby is pin level XOR polarity invert
// - Release processor reset at its power-up slot
// - Reset held released on; low at power-down
// - Interrupt pin low on any unmasked latch
// - Write one clears latch; pin then releases
// - Test bit pulses interrupt 100 us, self-clears
// - External input falling edge sets its latch
// - External status bit shows live pin level
// - Watchdog ignored until processor reset released
// - Watchdog edge chosen by edge-select fuse
// - Watchdog edge debounced for 10 us
// - Reset-type fuse picks hard or soft reset
// - Standby watchdog only when enable bit set
// - Early warning leads shutdown by selected time
// - Warning triggers: timer, count, thermal, overvoltage
// - Warning sets latch; low in off modes
// - Warning also on supply warning comparator
// - Mode zero: pin follows run/standby level
// - Level bits load one if sequenced, else zero
// - Mode one: pin is AND of selected monitors
// - Selected OV/UV latches interrupt; pin follows monitor good
// - Pin held low until reset release point
`timescale 1ns/1ps
`include "pmic_ctl_consts.svh"

module pmic_control_pin_logic
    import pmic_ctl_pkg::*;
#(
    parameter int NUM_MON = 11,
    parameter int EW_T1_CYC = `NS_TO_CYC(`EW_T1_NS),
    parameter int EW_T2_CYC = `NS_TO_CYC(`EW_T2_NS),
    parameter int EW_T3_CYC = `NS_TO_CYC(`EW_T3_NS)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic standby_pin_i,
    input wire logic external_irq_in_n_i,
    input wire logic watchdog_input_i,
    output logic processor_reset_out_n_o,
    output logic processor_reset_out_n_oe_o,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o,
    output logic early_warning_out_o,
    output logic power_good_pin_o,
    output logic power_good_pin_oe_o,
    // Sequencer and fault sources
    input wire logic power_up_req_i,
    input wire logic power_down_req_i,
    input wire logic [7:0] seq_slot_i,
    input wire logic [7:0] reset_release_slot_i,
    input wire logic [7:0] good_pin_sequence_slot_i,
    input wire logic [1:0] sequence_time_base_i,
    input wire logic fault_timer_expired_i,
    input wire logic [3:0] regulator_fault_count_i,
    input wire logic [3:0] regulator_fault_limit_i,
    input wire logic thermal_shutdown_i,
    input wire logic input_overvolt_i,
    input wire logic supply_warning_i,
    input wire logic [NUM_MON-1:0] monitor_good_i,
    input wire logic [NUM_MON-1:0] overvoltage_status_i,
    input wire logic [NUM_MON-1:0] undervoltage_status_i,
    // Fuse values
    input wire logic watchdog_edge_select_i,
    input wire logic watchdog_reset_type_i,
    input wire logic watchdog_standby_default_i,
    input wire logic power_good_mode_select_i,
    input wire logic [1:0] early_warning_lead_time_i,
    // Outputs to the rest of the device
    output logic standby_mode_o,
    output logic wd_hard_reset_o,
    output logic wd_soft_reset_o,
    output logic power_down_go_o
);

    localparam int IRQ_TEST_CYC = `NS_TO_CYC(`IRQ_TEST_NS);
    localparam int WD_DEB_CYC = `NS_TO_CYC(`WD_DEBOUNCE_NS);
    localparam int EW_T0_CYC = `NS_TO_CYC(`EW_T0_NS);
    localparam int CW = 21;

    // Word decode shared by read and write paths
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        return adr == reg_adr;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic standby_sync;
    logic ext_sync;
    logic wd_sync;

    // Two flops per pin before anything looks at them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
        end else begin
            sync1_q <= {watchdog_input_i, external_irq_in_n_i, standby_pin_i};
            sync2_q <= sync1_q;
        end
    end
    assign standby_sync = sync2_q[0];
    assign ext_sync = sync2_q[1];
    assign wd_sync = sync2_q[2];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [`IRQ_COUNT-1:0] latch_q;
    logic [`IRQ_COUNT-1:0] mask_q;
    logic [NUM_MON-1:0] mon_sel_q;
    logic wr_en;
    logic [`IRQ_COUNT-1:0] irq_set;
    logic [`IRQ_COUNT-1:0] irq_clr;
    logic loaded_q;
    logic test_done;
    sys_state_t state_q;

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign irq_clr = (wr_en && hit(wb_adr_i, `REG_IRQ_LATCH)) ? wb_dat_i[`IRQ_COUNT-1:0] : '0;

    // Control bits; level bits load from sequencing fuses once after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 6'h00;
            loaded_q <= 1'b0;
        end else begin
            if (!loaded_q) begin
                loaded_q <= 1'b1;
                ctrl_q[`CTRL_WD_STBY_EN] <= watchdog_standby_default_i;
                ctrl_q[`CTRL_RUN_LEVEL] <= (good_pin_sequence_slot_i != 8'h00);
                ctrl_q[`CTRL_STBY_LEVEL] <= (good_pin_sequence_slot_i != 8'h00);
            end else if (wr_en && hit(wb_adr_i, `REG_CTRL)) begin
                ctrl_q <= wb_dat_i[5:0];
            end else if (test_done) begin
                ctrl_q[`CTRL_IRQ_TEST] <= 1'b0;
            end
        end
    end

    // Mask and monitor select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `MASK_RESET;
            mon_sel_q <= NUM_MON'(`MON_SELECT_RESET);
        end else if (wr_en) begin
            if (hit(wb_adr_i, `REG_IRQ_MASK)) mask_q <= wb_dat_i[`IRQ_COUNT-1:0];
            if (hit(wb_adr_i, `REG_MON_SELECT)) mon_sel_q <= wb_dat_i[NUM_MON-1:0];
        end
    end

    // Sticky latches: a set in the clear cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= '0;
        end else begin
            latch_q <= (latch_q & ~irq_clr) | irq_set;
        end
    end

    // Bus answer one cycle after the request; unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (hit(wb_adr_i, `REG_CTRL)) wb_dat_o <= {26'h0, ctrl_q};
            if (hit(wb_adr_i, `REG_STATUS)) wb_dat_o <= {25'h0, state_q, early_warning_out_o,
                processor_reset_out_n_o, standby_mode_o, ext_sync};
            if (hit(wb_adr_i, `REG_IRQ_LATCH)) wb_dat_o <= {27'h0, latch_q};
            if (hit(wb_adr_i, `REG_IRQ_MASK)) wb_dat_o <= {27'h0, mask_q};
            if (hit(wb_adr_i, `REG_MON_SELECT)) wb_dat_o <= {{(32 - NUM_MON){1'b0}}, mon_sel_q};
            if (hit(wb_adr_i, `REG_OTP)) wb_dat_o <= {26'h0, early_warning_lead_time_i,
                power_good_mode_select_i, watchdog_standby_default_i, watchdog_reset_type_i,
                watchdog_edge_select_i};
        end
    end

    // ----------------------------------------------------------------
    // System state
    // ----------------------------------------------------------------
    logic ew_trigger;
    logic ew_done;
    logic standby_eff;
    logic [CW-1:0] ew_cnt_q;
    logic [CW-1:0] ew_len;

    assign standby_eff = standby_sync ^ ctrl_q[`CTRL_STBY_INV];
    assign ew_trigger = fault_timer_expired_i || thermal_shutdown_i || supply_warning_i
        || (regulator_fault_count_i == regulator_fault_limit_i)
        || (input_overvolt_i && ctrl_q[`CTRL_OVLO_SDWN]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_OFF;
        end else begin
            unique case (state_q)
                ST_OFF: if (power_up_req_i) state_q <= ST_POWER_UP;
                ST_POWER_UP: if (seq_slot_i >= reset_release_slot_i) state_q <= ST_RUN;
                ST_RUN, ST_STANDBY: begin
                    if (ew_trigger) state_q <= ST_WARN;
                    else if (power_down_req_i) state_q <= ST_POWER_DOWN;
                    else state_q <= standby_eff ? ST_STANDBY : ST_RUN;
                end
                ST_WARN: if (ew_done) state_q <= ST_POWER_DOWN;
                ST_POWER_DOWN: state_q <= ST_OFF;
            endcase
        end
    end

    // Lead time of the early warning
    always_comb begin
        unique case (early_warning_lead_time_i)
            2'b00: ew_len = CW'(EW_T0_CYC);
            2'b01: ew_len = CW'(EW_T1_CYC);
            2'b10: ew_len = CW'(EW_T2_CYC);
            default: ew_len = CW'(EW_T3_CYC);
        endcase
    end
    assign ew_done = (ew_cnt_q >= ew_len - CW'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != ST_WARN) ew_cnt_q <= '0;
        else ew_cnt_q <= ew_cnt_q + CW'(1);
    end

    // Pins driven from state; warning is low outside the warning phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            early_warning_out_o <= 1'b0;
            processor_reset_out_n_o <= 1'b0;
            standby_mode_o <= 1'b0;
            power_down_go_o <= 1'b0;
        end else begin
            early_warning_out_o <= (state_q == ST_WARN);
            processor_reset_out_n_o <= (state_q == ST_RUN || state_q == ST_STANDBY
                || state_q == ST_WARN);
            standby_mode_o <= (state_q == ST_STANDBY);
            power_down_go_o <= (state_q == ST_POWER_DOWN);
        end
    end
    assign processor_reset_out_n_oe_o = !processor_reset_out_n_o;

    // ----------------------------------------------------------------
    // Watchdog input
    // ----------------------------------------------------------------
    logic wd_stable_q;
    logic wd_cand;
    logic [9:0] wd_cnt_q;
    logic wd_event;
    logic wd_allowed;

    assign wd_cand = wd_sync ^ ~watchdog_edge_select_i; // High means asserted level
    assign wd_allowed = processor_reset_out_n_o
        && (state_q != ST_STANDBY || ctrl_q[`CTRL_WD_STBY_EN]);

    // Asserted level must hold the full debounce time before it counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_cnt_q <= '0;
            wd_stable_q <= 1'b1;
        end else if (wd_cand == wd_stable_q) begin
            wd_cnt_q <= '0;
        end else if (wd_cnt_q >= 10'(WD_DEB_CYC - 1)) begin
            wd_cnt_q <= '0;
            wd_stable_q <= wd_cand;
        end else begin
            wd_cnt_q <= wd_cnt_q + 10'd1;
        end
    end
    assign wd_event = wd_cand && !wd_stable_q && (wd_cnt_q >= 10'(WD_DEB_CYC - 1)) && wd_allowed;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_hard_reset_o <= 1'b0;
            wd_soft_reset_o <= 1'b0;
        end else begin
            wd_hard_reset_o <= wd_event && watchdog_reset_type_i;
            wd_soft_reset_o <= wd_event && !watchdog_reset_type_i;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt sources and pin
    // ----------------------------------------------------------------
    logic ext_prev_q;
    logic ew_prev_q;
    logic pg_armed;
    logic [12:0] test_cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev_q <= 1'b1;
            ew_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_sync;
            ew_prev_q <= early_warning_out_o;
        end
    end

    assign irq_set[`IRQ_EXT] = ext_prev_q && !ext_sync;
    assign irq_set[`IRQ_EARLY_WARNING_OUT] = early_warning_out_o && !ew_prev_q;
    assign irq_set[`IRQ_OV] = pg_armed && |(overvoltage_status_i & mon_sel_q);
    assign irq_set[`IRQ_UV] = pg_armed && |(undervoltage_status_i & mon_sel_q);
    assign irq_set[`IRQ_WD] = wd_event;

    // Test pulse timer
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctrl_q[`CTRL_IRQ_TEST]) test_cnt_q <= '0;
        else if (!test_done) test_cnt_q <= test_cnt_q + 13'd1;
    end
    assign test_done = ctrl_q[`CTRL_IRQ_TEST] && test_cnt_q >= 13'(IRQ_TEST_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i) interrupt_out_n_o <= 1'b1;
        else interrupt_out_n_o <= !(|(latch_q & ~mask_q) || ctrl_q[`CTRL_IRQ_TEST]);
    end
    assign interrupt_out_n_oe_o = !interrupt_out_n_o;

    // ----------------------------------------------------------------
    // Power-good pin
    // ----------------------------------------------------------------
    assign pg_armed = processor_reset_out_n_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_good_pin_o <= 1'b0;
        end else if (power_good_mode_select_i) begin
            power_good_pin_o <= pg_armed && &(monitor_good_i | ~mon_sel_q);
        end else begin
            unique case (state_q)
                ST_RUN, ST_WARN: power_good_pin_o <= ctrl_q[`CTRL_RUN_LEVEL];
                ST_STANDBY: power_good_pin_o <= ctrl_q[`CTRL_STBY_LEVEL];
                default: power_good_pin_o <= 1'b0;
            endcase
        end
    end
    assign power_good_pin_oe_o = !power_good_pin_o;

endmodule // pmic_control_pin_logic

// ==== pmic_ctl_checker_properties.sv ====
// Concurrent checks on the ports of the control-pin block
`timescale 1ns/1ps
module pmic_ctl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic processor_reset_out_n_o,
    input wire logic processor_reset_out_n_oe_o,
    input wire logic interrupt_out_n_o,
    input wire logic interrupt_out_n_oe_o,
    input wire logic early_warning_out_o,
    input wire logic power_good_pin_o,
    input wire logic watchdog_input_i,
    input wire logic watchdog_edge_select_i,
    input wire logic watchdog_reset_type_i,
    input wire logic thermal_shutdown_i,
    input wire logic wd_hard_reset_o,
    input wire logic wd_soft_reset_o,
    input wire logic power_down_go_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Either watchdog reset pulse
    sequence wd_event;
        wd_hard_reset_o || wd_soft_reset_o;
    endsequence
    // Two cycles with the processor held in reset, so a pulse from the edge that drops it is excused
    sequence reset_held;
        !processor_reset_out_n_o [*2];
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stood longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
    reset_drive_a: assert property (processor_reset_out_n_oe_o == !processor_reset_out_n_o)
        else $error("reset pin enable wrong");
    irq_drive_a: assert property (interrupt_out_n_oe_o == !interrupt_out_n_o)
        else $error("interrupt pin enable wrong");
    wd_type_a: assert property (wd_event |-> wd_hard_reset_o == watchdog_reset_type_i)
        else $error("watchdog reset kind wrong");
    wd_debounce_a: assert property (wd_event |-> $past(watchdog_input_i, 8) == watchdog_edge_select_i)
        else $error("watchdog event without settled input");
    wd_masked_a: assert property (reset_held |-> !wd_hard_reset_o && !wd_soft_reset_o)
        else $error("watchdog event while processor in reset");
    warn_trigger_a: assert property ($rose(thermal_shutdown_i) && processor_reset_out_n_o |-> ##[1:6] early_warning_out_o)
        else $error("thermal fault gave no warning");
    warn_lead_a: assert property ($rose(early_warning_out_o) |-> !power_down_go_o [*8])
        else $error("power down without lead time");
    off_quiet_a: assert property ($fell(rst_i) |-> !early_warning_out_o && !power_good_pin_o)
        else $error("pins active in off mode");
endmodule // pmic_ctl_checker

bind pmic_control_pin_logic pmic_ctl_checker pmic_ctl_checker_i (.*);

// ==== pmic_host_model.sv ====
// Far-side model: processor watchdog and standby pins, companion interrupt line
`timescale 1ns/1ps
module pmic_host_model (
    input wire logic clk_i,
    output logic standby_pin_o,
    output logic ext_irq_n_o,
    output logic watchdog_o
);
    // Idle levels: companion line pulled up, processor holds watchdog high
    initial begin
        standby_pin_o = 1'b0;
        ext_irq_n_o = 1'b1;
        watchdog_o = 1'b1;
    end
    // Falling edge held n cycles; short holds model glitches
    task automatic pulse_wd(input int n);
        @(posedge clk_i);
        watchdog_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        watchdog_o <= 1'b1;
    endtask
    // Companion raises or releases its interrupt
    task automatic ext_level(input logic v);
        @(posedge clk_i);
        ext_irq_n_o <= v;
    endtask
    // Processor moves the standby pin
    task automatic set_standby(input logic v);
        @(posedge clk_i);
        standby_pin_o <= v;
    endtask
endmodule // pmic_host_model

// ==== tb_pmic_control_pin_logic.sv ====
// Self-checking testbench of the control-pin block
`timescale 1ns/1ps
`include "pmic_ctl_consts.svh"
module tb_pmic_control_pin_logic;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00, seq_slot_i = 8'h00, reset_release_slot_i = 8'h03, good_pin_sequence_slot_i = 8'h02;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0] wb_sel_i = 4'hF, regulator_fault_count_i = 4'h0, regulator_fault_limit_i = 4'hF;
    logic [1:0] sequence_time_base_i = 2'h1, early_warning_lead_time_i = 2'h1;
    logic power_up_req_i = 0, power_down_req_i = 0, fault_timer_expired_i = 0, thermal_shutdown_i = 0;
    logic input_overvolt_i = 0, supply_warning_i = 0, watchdog_edge_select_i = 0, watchdog_reset_type_i = 0;
    logic watchdog_standby_default_i = 0, power_good_mode_select_i = 0;
    logic [10:0] monitor_good_i = 11'h7FF, overvoltage_status_i = 11'h000, undervoltage_status_i = 11'h000;
    wire logic standby_pin_i, external_irq_in_n_i, watchdog_input_i;
    logic processor_reset_out_n_o, processor_reset_out_n_oe_o, interrupt_out_n_o, interrupt_out_n_oe_o;
    logic early_warning_out_o, power_good_pin_o, power_good_pin_oe_o, standby_mode_o;
    logic wd_hard_reset_o, wd_soft_reset_o, power_down_go_o;
    int errors = 0, n_compared = 0, wd_cnt = 0, n;
    pmic_control_pin_logic #(.EW_T1_CYC(20), .EW_T2_CYC(40), .EW_T3_CYC(60)) pmic_control_pin_logic_i (.*);
    pmic_host_model pmic_host_model_i (.clk_i(clk_i), .standby_pin_o(standby_pin_i),
        .ext_irq_n_o(external_irq_in_n_i), .watchdog_o(watchdog_input_i));
    // Clock, 25 ns period
    always #12.5 clk_i = ~clk_i;
    // Count soft watchdog pulses; hard pulses, selected from the hard-kind test on, are not counted
    always @(posedge clk_i) if (wd_soft_reset_o === 1'b1) wd_cnt <= wd_cnt + 1;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask
    // Classic cycle: request held until ack is seen at an edge, then released
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (k >= 50) errors++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk_w(q & m, exp);
    endtask
    // Bounded wait for a pin level, then compare
    task automatic wait_pin(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge clk_i);
            k++;
        end
        chk_b(s, v);
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_b(processor_reset_out_n_o, 1'b0);
        chk_b(interrupt_out_n_o, 1'b1);
        rd(`REG_CTRL, 32'hFF, 32'h18);
        rd(`REG_IRQ_MASK, 32'hFF, 32'h1F);
        rd(`REG_MON_SELECT, 32'h7FF, 32'h7FF);
        // Write without the low byte lane is refused
        wb_sel_i <= 4'hE;
        wr(`REG_IRQ_MASK, 32'h0);
        wb_sel_i <= 4'hF;
        rd(`REG_IRQ_MASK, 32'hFF, 32'h1F);
        wr(8'h20, 32'hFF);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
        // Power-up: reset and good pin stay low before the release slot
        power_up_req_i <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            seq_slot_i <= 8'(s);
            repeat (8) @(posedge clk_i);
            chk_b(processor_reset_out_n_o | power_good_pin_o, 1'b0);
        end
        seq_slot_i <= 8'h03;
        wait_pin(processor_reset_out_n_o, 1'b1, 20);
        wait_pin(power_good_pin_o, 1'b1, 20);
        wr(`REG_CTRL, 32'h10);
        wait_pin(power_good_pin_o, 1'b0, 10);
        pmic_host_model_i.set_standby(1'b1);
        wait_pin(standby_mode_o, 1'b1, 10);
        wait_pin(power_good_pin_o, 1'b1, 10);
        pmic_host_model_i.pulse_wd(420);
        repeat (20) @(posedge clk_i);
        chk_w(32'(wd_cnt), 32'h0);
        wr(`REG_CTRL, 32'h11);
        wait_pin(standby_mode_o, 1'b0, 10);
        pmic_host_model_i.set_standby(1'b0);
        wait_pin(standby_mode_o, 1'b1, 10);
        pmic_host_model_i.set_standby(1'b1);
        wait_pin(standby_mode_o, 1'b0, 10);
        // External interrupt: live level, latch, write-one clear
        wr(`REG_IRQ_MASK, 32'h1E);
        pmic_host_model_i.ext_level(1'b0);
        wait_pin(interrupt_out_n_o, 1'b0, 10);
        rd(`REG_STATUS, 32'h1, 32'h0);
        pmic_host_model_i.ext_level(1'b1);
        repeat (6) @(posedge clk_i);
        rd(`REG_STATUS, 32'h1, 32'h1);
        rd(`REG_IRQ_LATCH, 32'h1, 32'h1);
        chk_b(interrupt_out_n_o, 1'b0);
        wr(`REG_IRQ_LATCH, 32'h1);
        wait_pin(interrupt_out_n_o, 1'b1, 10);
        // Test pulse on the interrupt pin with all sources masked
        wr(`REG_IRQ_MASK, 32'h1F);
        wr(`REG_CTRL, 32'h13);
        wait_pin(interrupt_out_n_o, 1'b0, 10);
        repeat (3900) @(posedge clk_i);
        chk_b(interrupt_out_n_o, 1'b0);
        wait_pin(interrupt_out_n_o, 1'b1, 300);
        rd(`REG_CTRL, 32'h2, 32'h0);
        // Power-good AND of selected monitors
        power_good_mode_select_i <= 1'b1;
        wait_pin(power_good_pin_o, 1'b1, 10);
        monitor_good_i <= 11'h7DF;
        overvoltage_status_i <= 11'h020;
        wait_pin(power_good_pin_o, 1'b0, 10);
        overvoltage_status_i <= 11'h000;
        wr(`REG_MON_SELECT, 32'h7DF);
        wait_pin(power_good_pin_o, 1'b1, 10);
        rd(`REG_IRQ_LATCH, 32'h4, 32'h4);
        undervoltage_status_i <= 11'h001;
        monitor_good_i <= 11'h7DE;
        wait_pin(power_good_pin_o, 1'b0, 10);
        undervoltage_status_i <= 11'h000;
        monitor_good_i <= 11'h7DF;
        wait_pin(power_good_pin_o, 1'b1, 10);
        rd(`REG_IRQ_LATCH, 32'h8, 32'h8);
        // Watchdog: glitch ignored, full hold gives one soft pulse
        pmic_host_model_i.pulse_wd(200);
        repeat (20) @(posedge clk_i);
        chk_w(32'(wd_cnt), 32'h0);
        pmic_host_model_i.pulse_wd(420);
        repeat (20) @(posedge clk_i);
        chk_w(32'(wd_cnt), 32'h1);
        // Hard kind: no soft pulse, latch still set; debouncer first settles back
        repeat (420) @(posedge clk_i);
        watchdog_reset_type_i <= 1'b1;
        wr(`REG_IRQ_LATCH, 32'h10);
        pmic_host_model_i.pulse_wd(420);
        repeat (20) @(posedge clk_i);
        chk_w(32'(wd_cnt), 32'h1);
        rd(`REG_IRQ_LATCH, 32'h10, 32'h10);
        // Every fault source in turn; the device powers back up between them
        wr(`REG_CTRL, 32'h31);
        for (int t = 0; t < 5; t++) begin
            early_warning_lead_time_i <= 2'(t % 3 + 1);
            case (t)
                0: thermal_shutdown_i <= 1'b1;
                1: fault_timer_expired_i <= 1'b1;
                2: regulator_fault_count_i <= 4'hF;
                3: supply_warning_i <= 1'b1;
                default: input_overvolt_i <= 1'b1;
            endcase
            wait_pin(early_warning_out_o, 1'b1, 10);
            {thermal_shutdown_i, fault_timer_expired_i, supply_warning_i, input_overvolt_i} <= 4'h0;
            regulator_fault_count_i <= 4'h0;
            n = 0;
            while (power_down_go_o !== 1'b1 && n < 100) begin
                @(posedge clk_i);
                n++;
            end
            chk_b(n >= 20 * (t % 3 + 1) - 2 && n <= 20 * (t % 3 + 1) + 4, 1'b1);
            rd(`REG_IRQ_LATCH, 32'h2, 32'h2);
            wr(`REG_IRQ_LATCH, 32'h2);
        end
        // Orderly power down with the request held off
        power_up_req_i <= 1'b0;
        power_down_req_i <= 1'b1;
        wait_pin(processor_reset_out_n_o, 1'b0, 100);
        pmic_host_model_i.pulse_wd(420);
        repeat (20) @(posedge clk_i);
        chk_w(32'(wd_cnt), 32'h1);
        results();
    end
    // Watchdog on the run itself
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        results();
    end
endmodule // tb_pmic_control_pin_logic
